// *** psc_cable_test.sv ***
// Cable diagnostic sequencer for one port: start bit, result capture.
// Assumes the transceiver answers each start pulse with one done pulse.
`timescale 1ns/1ps
module psc_cable_test
    import psc_pkg::*;
#(
    parameter int COUNT_W = 9
) (
    input wire logic mclk,
    input wire logic rst,
    input wire logic ce,
    psc_port_if.test pif,
    input wire logic phy_done,
    input wire logic [1:0] phy_result,
    input wire logic phy_short,
    input wire logic [COUNT_W-1:0] phy_count,
    output logic phy_start
);

    typedef enum logic [0:0] {
        PSC_CT_IDLE = 1'b0,
        PSC_CT_RUN = 1'b1
    } psc_ct_state_t;

    psc_ct_state_t state_q;
    logic take_start;
    logic take_done;

    // A start while running is ignored; software cannot abort a test.
    assign take_start = pif.start_we && (state_q == PSC_CT_IDLE);
    assign take_done = phy_done && (state_q == PSC_CT_RUN);
    assign pif.busy = (state_q == PSC_CT_RUN);

    // Busy holds from the start write until the transceiver reports done.
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            state_q <= PSC_CT_IDLE;
            phy_start <= 1'b0;
            pif.done_evt <= 1'b0;
        end else if (ce) begin
            phy_start <= take_start;
            pif.done_evt <= take_done;
            unique case (state_q)
                PSC_CT_IDLE: begin
                    if (take_start) begin
                        state_q <= PSC_CT_RUN;
                    end
                end
                PSC_CT_RUN: begin
                    if (take_done) begin
                        state_q <= PSC_CT_IDLE;
                    end
                end
            endcase
        end
    end

    // Results are latched only at completion so a read after busy drops is stable.
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            pif.result <= PSC_RES_NORMAL;
            pif.short_q <= 1'b0;
            pif.count <= '0;
        end else if (ce && take_done) begin
            pif.result <= phy_result;
            pif.short_q <= phy_short;
            pif.count <= phy_count;
        end
    end

endmodule : psc_cable_test

// *** psc_ctrl_bits.sv ***
// Shared storage for one port's force link, power saving and loopback bits.
// Assumes writes from either register view arrive already merged on ctrl_we.
`timescale 1ns/1ps
module psc_ctrl_bits
    import psc_pkg::*;
(
    input wire logic mclk,
    input wire logic rst,
    input wire logic ce,
    psc_port_if.ctrl pif
);

    // One flop per bit serves both views, so they can never disagree.
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            pif.ctrl_q <= CTRL_RESET;
        end else if (ce && pif.ctrl_we) begin
            pif.ctrl_q <= pif.ctrl_wd;
        end
    end

endmodule : psc_ctrl_bits

// *** psc_pkg.sv ***
// Package for the transceiver special control and cable test register bank.
// Assumes a 16-bit register port addressed as {bank, byte offset}.
package psc_pkg;

    // Register word and address layout.
    localparam int REG_W = 16;
    localparam int ADDR_W = 16;
    localparam int BANK_LSB = 8;
    localparam int PORTS = 2;

    // Bank numbers: the switch view and the two transceiver views.
    localparam logic [7:0] BANK_SWITCH = 8'h2F;
    localparam logic [7:0] BANK_PHY [PORTS] = '{8'h31, 8'h33};

    // Offsets in the switch bank: a cable test and a control entry per port, then the shared interrupt status and mask.
    localparam logic [7:0] OFF_TEST [PORTS] = '{8'h00, 8'h04};
    localparam logic [7:0] OFF_CTRL [PORTS] = '{8'h02, 8'h06};
    localparam logic [7:0] OFF_IRQ_STAT = 8'h08;
    localparam logic [7:0] OFF_IRQ_MASK = 8'h0A;

    // Offsets in each transceiver bank.
    localparam logic [7:0] OFF_PHY_CTRL = 8'h00;
    localparam logic [7:0] OFF_PHY_STAT = 8'h04;

    // Special control/status field positions.
    localparam int SC_POL = 5;
    localparam int SC_XOVER = 4;
    localparam int SC_FORCE = 3;
    localparam int SC_PWR = 2;
    localparam int SC_LOOP = 1;

    // Cable test register field positions.
    localparam int CT_START = 15;
    localparam int CT_RES_LSB = 13;
    localparam int CT_SHORT = 12;
    localparam int CT_CNT_LSB = 0;

    // Transceiver control register field positions.
    localparam int PC_SHORT = 15;
    localparam int PC_RES_LSB = 13;
    localparam int PC_START = 12;
    localparam int PC_FORCE = 11;
    localparam int PC_PWR = 10;
    localparam int PC_LOOP = 9;
    localparam int PC_CNT_LSB = 0;

    // Transceiver status register field positions.
    localparam int PS_POL = 13;
    localparam int PS_XOVER = 7;

    // Control bits travel as {force, power save off, loopback}.
    localparam logic [2:0] CTRL_RESET = 3'h2;

    // Cable test result codes.
    typedef enum logic [1:0] {
        PSC_RES_NORMAL = 2'b00,
        PSC_RES_OPEN = 2'b01,
        PSC_RES_SHORT = 2'b10,
        PSC_RES_FAIL = 2'b11
    } psc_result_t;

    // Interrupt status layout: test done, polarity change, crossover change.
    localparam int EV_W = 6;
    localparam int EV_DONE_LSB = 0;
    localparam int EV_POL_LSB = 2;
    localparam int EV_XOVER_LSB = 4;

endpackage : psc_pkg

// *** psc_port_if.sv ***
// Interface between the register bank and one port's field storage.
// Assumes one instance per transceiver port, all on mclk.
`timescale 1ns/1ps
interface psc_port_if #(
    parameter int COUNT_W = 9
);
    logic ctrl_we;
    logic [2:0] ctrl_wd;
    logic [2:0] ctrl_q;
    logic start_we;
    logic busy;
    logic [1:0] result;
    logic short_q;
    logic [COUNT_W-1:0] count;
    logic done_evt;

    modport bank (output ctrl_we, output ctrl_wd, output start_we, input ctrl_q,
                  input busy, input result, input short_q, input count, input done_evt);
    modport ctrl (input ctrl_we, input ctrl_wd, output ctrl_q);
    modport test (input start_we, output busy, output result, output short_q,
                  output count, output done_evt);
endinterface : psc_port_if

// *** psc_regs.sv ***
// Register bank for the special control/status and cable test registers of
// two transceiver ports, with the transceiver-bank aliases and an interrupt.
// Assumes a single-cycle register port on mclk; reads answer one cycle later.
`timescale 1ns/1ps
module psc_regs
    import psc_pkg::*;
#(
    parameter int COUNT_W = 9
) (
    input wire logic mclk,
    input wire logic rst,
    input wire logic ce,
    input wire logic [ADDR_W-1:0] reg_addr,
    input wire logic [REG_W-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [REG_W-1:0] reg_rdata,
    output logic irq,
    input wire logic [PORTS-1:0] polarity_reversed,
    input wire logic [PORTS-1:0] crossover_state,
    output logic [PORTS-1:0] force_link,
    output logic [PORTS-1:0] power_save_off,
    output logic [PORTS-1:0] near_loopback,
    output logic [PORTS-1:0] test_start,
    input wire logic [PORTS-1:0] test_done,
    input wire logic [2*PORTS-1:0] test_result,
    input wire logic [PORTS-1:0] test_short,
    input wire logic [PORTS*COUNT_W-1:0] test_count
);

    ////////////////////////////////////////////////////////////////////////////
    // Address decode.
    ////////////////////////////////////////////////////////////////////////////

    logic [7:0] addr_bank;
    logic [7:0] addr_off;
    logic in_switch;
    logic sel_irq_stat;
    logic sel_irq_mask;

    // The bank sits in the upper byte, the printed offset in the lower.
    assign addr_bank = reg_addr[ADDR_W-1:BANK_LSB];
    assign addr_off = reg_addr[BANK_LSB-1:0];
    assign in_switch = (addr_bank == BANK_SWITCH);
    assign sel_irq_stat = in_switch && (addr_off == OFF_IRQ_STAT);
    assign sel_irq_mask = in_switch && (addr_off == OFF_IRQ_MASK);

    ////////////////////////////////////////////////////////////////////////////
    // Status input history for change events.
    ////////////////////////////////////////////////////////////////////////////

    logic [PORTS-1:0] pol_q;
    logic [PORTS-1:0] xover_q;
    logic hist_ok_q;
    logic [PORTS-1:0] pol_chg;
    logic [PORTS-1:0] xover_chg;

    // Inputs are synchronous; one stage of history gives the change strobes.
    // The history is only trusted after one enabled edge, because the reset
    // value need not match the pin levels and would fake a change event.
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            pol_q <= '0;
            xover_q <= '0;
            hist_ok_q <= 1'b0;
        end else if (ce) begin
            pol_q <= polarity_reversed;
            xover_q <= crossover_state;
            hist_ok_q <= 1'b1;
        end
    end

    // Change strobes, held off until the history holds real pin levels.
    assign pol_chg = hist_ok_q ? (pol_q ^ polarity_reversed) : '0;
    assign xover_chg = hist_ok_q ? (xover_q ^ crossover_state) : '0;

    ////////////////////////////////////////////////////////////////////////////
    // Per-port field storage and register words.
    ////////////////////////////////////////////////////////////////////////////

    logic [PORTS-1:0] sel_test;
    logic [PORTS-1:0] sel_ctrl;
    logic [PORTS-1:0] sel_phy_ctrl;
    logic [PORTS-1:0] sel_phy_stat;
    logic [PORTS-1:0] done_evt;
    logic [REG_W-1:0] word_test [PORTS];
    logic [REG_W-1:0] word_ctrl [PORTS];
    logic [REG_W-1:0] word_phy_ctrl [PORTS];
    logic [REG_W-1:0] word_phy_stat [PORTS];

    genvar g;
    generate
        for (g = 0; g < PORTS; g++) begin : port
            psc_port_if #(.COUNT_W(COUNT_W)) pif ();

            // Each port owns one switch-bank pair and one transceiver bank.
            assign sel_test[g] = in_switch && (addr_off == OFF_TEST[g]);
            assign sel_ctrl[g] = in_switch && (addr_off == OFF_CTRL[g]);
            assign sel_phy_ctrl[g] = (addr_bank == BANK_PHY[g])
                                     && (addr_off == OFF_PHY_CTRL);
            assign sel_phy_stat[g] = (addr_bank == BANK_PHY[g])
                                     && (addr_off == OFF_PHY_STAT);

            // Either view writes the same control flops; the field sits
            // at different bit positions in each view.
            assign pif.ctrl_we = reg_wr && (sel_ctrl[g] || sel_phy_ctrl[g]);
            assign pif.ctrl_wd = sel_ctrl[g]
                                 ? {reg_wdata[SC_FORCE], reg_wdata[SC_PWR],
                                    reg_wdata[SC_LOOP]}
                                 : {reg_wdata[PC_FORCE], reg_wdata[PC_PWR],
                                    reg_wdata[PC_LOOP]};

            // A written zero to the start bit has no effect: only hardware
            // clears it, so a stray write cannot fake a completed test.
            assign pif.start_we = reg_wr
                                  && ((sel_test[g] && reg_wdata[CT_START])
                                  || (sel_phy_ctrl[g] && reg_wdata[PC_START]));

            psc_ctrl_bits u_ctrl (
                .mclk(mclk),
                .rst(rst),
                .ce(ce),
                .pif(pif)
            );

            psc_cable_test #(.COUNT_W(COUNT_W)) u_test (
                .mclk(mclk),
                .rst(rst),
                .ce(ce),
                .pif(pif),
                .phy_done(test_done[g]),
                .phy_result(test_result[2*g +: 2]),
                .phy_short(test_short[g]),
                .phy_count(test_count[g*COUNT_W +: COUNT_W]),
                .phy_start(test_start[g])
            );

            // Control outputs come straight from the shared flops.
            assign force_link[g] = pif.ctrl_q[2];
            assign power_save_off[g] = pif.ctrl_q[1];
            assign near_loopback[g] = pif.ctrl_q[0];
            assign done_evt[g] = pif.done_evt;

            // Switch-bank special control/status word; upper bits are zero.
            assign word_ctrl[g] = {10'h000, polarity_reversed[g], crossover_state[g],
                                   pif.ctrl_q, 1'b0};

            // Switch-bank cable test word; bits 11 to 9 are zero.
            assign word_test[g] = {pif.busy, pif.result, pif.short_q, 3'h0,
                                   pif.count};

            // Transceiver control word: the same flops in a second layout.
            assign word_phy_ctrl[g] = {pif.short_q, pif.result, pif.busy, pif.ctrl_q,
                                       pif.count};

            // Transceiver status word shows the two live status inputs.
            assign word_phy_stat[g] = {2'h0, polarity_reversed[g], 5'h00,
                                       crossover_state[g], 7'h00};
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////
    // Interrupt status and mask.
    ////////////////////////////////////////////////////////////////////////////

    logic [EV_W-1:0] irq_stat_q;
    logic [EV_W-1:0] irq_stat_d;
    logic [EV_W-1:0] irq_mask_q;
    logic [EV_W-1:0] irq_set;
    logic [EV_W-1:0] irq_clr;
    logic irq_d;

    // Events: test completion and any change of polarity or crossover.
    assign irq_set = {xover_chg, pol_chg, done_evt};

    // Write one to clear; a new event in the same cycle keeps its bit set.
    assign irq_clr = (reg_wr && sel_irq_stat) ? reg_wdata[EV_W-1:0] : '0;
    assign irq_stat_d = (irq_stat_q & ~irq_clr) | irq_set;
    assign irq_d = |(irq_stat_d & irq_mask_q);

    // The output is registered from the next status so it tracks the bits.
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            irq_stat_q <= '0;
            irq <= 1'b0;
        end else if (ce) begin
            irq_stat_q <= irq_stat_d;
            irq <= irq_d;
        end
    end

    // The mask resets to all zero so nothing fires before software opts in.
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            irq_mask_q <= '0;
        end else if (ce && reg_wr && sel_irq_mask) begin
            irq_mask_q <= reg_wdata[EV_W-1:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Read path.
    ////////////////////////////////////////////////////////////////////////////

    logic [REG_W-1:0] rd_mux;
    logic [REG_W-1:0] rd_ports;

    // Port words are ORed together; at most one select is ever high.
    always_comb begin
        rd_ports = '0;
        for (int i = 0; i < PORTS; i++) begin
            rd_ports = rd_ports
                       | ({REG_W{sel_test[i]}} & word_test[i])
                       | ({REG_W{sel_ctrl[i]}} & word_ctrl[i])
                       | ({REG_W{sel_phy_ctrl[i]}} & word_phy_ctrl[i])
                       | ({REG_W{sel_phy_stat[i]}} & word_phy_stat[i]);
        end
    end

    // Unmapped addresses read as zero.
    assign rd_mux = rd_ports
                    | ({REG_W{sel_irq_stat}} & {{(REG_W-EV_W){1'b0}}, irq_stat_q})
                    | ({REG_W{sel_irq_mask}} & {{(REG_W-EV_W){1'b0}}, irq_mask_q});

    // Read data stands only in the cycle after the strobe, zero in other enabled cycles.
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            reg_rdata <= '0;
        end else if (ce) begin
            reg_rdata <= reg_rd ? rd_mux : '0;
        end
    end

endmodule : psc_regs

// *** psc_regs_sva.sv ***
// Checker for the special control/status and cable test register bank.
// Assumes it is bound to psc_regs and sees only that module's ports.
`timescale 1ns/1ps
module psc_regs_sva
    import psc_pkg::*;
#(
    parameter int COUNT_W = 9
) (
    input wire logic mclk,
    input wire logic rst,
    input wire logic ce,
    input wire logic [ADDR_W-1:0] reg_addr,
    input wire logic [REG_W-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [REG_W-1:0] reg_rdata,
    input wire logic irq,
    input wire logic [PORTS-1:0] polarity_reversed,
    input wire logic [PORTS-1:0] crossover_state,
    input wire logic [PORTS-1:0] force_link,
    input wire logic [PORTS-1:0] power_save_off,
    input wire logic [PORTS-1:0] near_loopback,
    input wire logic [PORTS-1:0] test_start,
    input wire logic [PORTS-1:0] test_done,
    input wire logic [2*PORTS-1:0] test_result,
    input wire logic [PORTS-1:0] test_short,
    input wire logic [PORTS*COUNT_W-1:0] test_count
);
    ////////////////////////////////////////////////////////////////////////////////
    // Decodes of the accesses that the properties key on.
    wire rd_sp1 = ce && reg_rd && (reg_addr == 16'h2F02);
    wire rd_ct2 = ce && reg_rd && (reg_addr == 16'h2F04);
    wire start2_wr = ce && reg_wr && (((reg_addr == 16'h2F04) && reg_wdata[15]) ||
                                      ((reg_addr == 16'h3300) && reg_wdata[12]));
    wire irq_wr = ce && reg_wr && ((reg_addr == 16'h2F08) || (reg_addr == 16'h2F0A));
    logic [PORTS-1:0] pol_q;
    logic [PORTS-1:0] xov_q;
    // Any cause that may move the interrupt line; a superset is enough here.
    wire cause = irq_wr || (|test_done) || (pol_q != polarity_reversed) ||
                 (xov_q != crossover_state);

    // Previous input levels, so that a change counts as a cause.
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            pol_q <= '0;
            xov_q <= '0;
        end else begin
            pol_q <= polarity_reversed;
            xov_q <= crossover_state;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Assertions on the register port and the transceiver side.
    property p_rsvd_zero;
        @(posedge mclk) disable iff (rst) rd_sp1 |=> (reg_rdata[15:6] == 10'h000);
    endproperty
    a_rsvd_zero: assert property (p_rsvd_zero) else $error("Reserved bits not zero.");
    property p_idle_rdata;
        @(posedge mclk) disable iff (rst) (ce && !reg_rd) |=> (reg_rdata == 16'h0000);
    endproperty
    a_idle_rdata: assert property (p_idle_rdata) else $error("Read data not idle.");
    property p_status_bits;
        @(posedge mclk) disable iff (rst)
        rd_sp1 |=> (reg_rdata[5:4] == {$past(polarity_reversed[0]), $past(crossover_state[0])});
    endproperty
    a_status_bits: assert property (p_status_bits) else $error("Status bits wrong.");
    property p_ctrl_view;
        @(posedge mclk) disable iff (rst)
        rd_sp1 |=> (reg_rdata[3:1] == {$past(force_link[0]), $past(power_save_off[0]),
                                        $past(near_loopback[0])});
    endproperty
    a_ctrl_view: assert property (p_ctrl_view) else $error("Control readback wrong.");
    property p_reset_vals;
        @(posedge mclk) disable iff (rst)
        $fell(rst) |-> (force_link == 2'b00) && (power_save_off == 2'b11) &&
                       (near_loopback == 2'b00) && (test_start == 2'b00);
    endproperty
    a_reset_vals: assert property (p_reset_vals) else $error("Reset values wrong.");
    property p_start_pulse;
        @(posedge mclk) disable iff (rst) test_start[1] |=> !test_start[1];
    endproperty
    a_start_pulse: assert property (p_start_pulse) else $error("Start pulse too long.");
    property p_start_cause;
        @(posedge mclk) disable iff (rst) test_start[1] |-> $past(start2_wr);
    endproperty
    a_start_cause: assert property (p_start_cause) else $error("Start without write.");
    property p_busy_read;
        @(posedge mclk) disable iff (rst)
        (rd_ct2 && $past(test_start[1]) && !$past(test_done[1])) |=> reg_rdata[15];
    endproperty
    a_busy_read: assert property (p_busy_read) else $error("Start bit not held.");
    property p_irq_rise;
        @(posedge mclk) disable iff (rst)
        $rose(irq) |-> ($past(cause) || $past(cause, 2) || $past(cause, 3));
    endproperty
    a_irq_rise: assert property (p_irq_rise) else $error("Interrupt without cause.");
    property p_irq_fall;
        @(posedge mclk) disable iff (rst) $fell(irq) |-> ($past(irq_wr) || $past(irq_wr, 2));
    endproperty
    a_irq_fall: assert property (p_irq_fall) else $error("Interrupt dropped alone.");
endmodule : psc_regs_sva

bind psc_regs psc_regs_sva #(.COUNT_W(COUNT_W)) i_psc_regs_sva (.mclk(mclk), .rst(rst),
    .ce(ce), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .irq(irq), .polarity_reversed(polarity_reversed),
    .crossover_state(crossover_state), .force_link(force_link),
    .power_save_off(power_save_off), .near_loopback(near_loopback),
    .test_start(test_start), .test_done(test_done), .test_result(test_result),
    .test_short(test_short), .test_count(test_count));

// *** psc_regs_tb.sv ***
// Self-checking testbench for the special control and cable test register bank.
// Assumes the bank answers reads one cycle after the strobe and never stalls.
`timescale 1ns/1ps
module psc_regs_tb;
    import psc_pkg::*;
    logic mclk = 1'b0;
    logic rst = 1'b1;
    logic ce = 1'b1;
    logic [15:0] reg_addr = 16'h0000;
    logic [15:0] reg_wdata = 16'h0000;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [15:0] reg_rdata;
    logic irq;
    logic [1:0] polarity_reversed = 2'b00;
    logic [1:0] crossover_state = 2'b11;
    logic [1:0] force_link;
    logic [1:0] power_save_off;
    logic [1:0] near_loopback;
    logic [1:0] test_start;
    logic [1:0] test_done = 2'b00;
    logic [3:0] test_result = 4'h0;
    logic [1:0] test_short = 2'b00;
    logic [17:0] test_count = 18'h00000;
    logic [15:0] prev_word [2] = '{16'h0000, 16'h0000};
    int err_count = 0;
    int tests_run = 0;

    psc_regs #(.COUNT_W(9)) i_psc_regs (.mclk(mclk), .rst(rst), .ce(ce), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .irq(irq), .polarity_reversed(polarity_reversed), .crossover_state(crossover_state),
        .force_link(force_link), .power_save_off(power_save_off),
        .near_loopback(near_loopback), .test_start(test_start), .test_done(test_done),
        .test_result(test_result), .test_short(test_short), .test_count(test_count));

    // Clock at 40 MHz.
    always #12.5 mclk = ~mclk;

    ////////////////////////////////////////////////////////////////////////////////
    // Comparison, verdict and bus tasks.
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        tests_run++;
        if (seen !== exp) begin
            err_count++;
            $display("BAD at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic final_report();
        $display("Checks run %0d, mismatches %0d", tests_run, err_count);
        if (err_count == 0 && tests_run > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : final_report

    task automatic wr(input logic [15:0] a, input logic [15:0] d);
        @(posedge mclk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge mclk);
        reg_wr <= 1'b0;
    endtask : wr

    // The read data stand only in the cycle after the strobe, so look there.
    task automatic rd(input logic [15:0] a, input logic [15:0] exp);
        @(posedge mclk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge mclk);
        reg_rd <= 1'b0;
        #1 check(reg_rdata, exp);
    endtask : rd

    // One full cable test; the live result inputs are scrambled afterwards,
    // so a design that shows them unlatched is caught.
    task automatic run_test(input int g, input logic [15:0] sa, input logic [15:0] sd,
        input logic [1:0] code, input logic sh, input logic [8:0] cnt, input logic [15:0] ta);
        logic [15:0] exp;
        exp = {1'b0, code, sh, 3'b000, cnt};
        wr(sa, sd);
        #1 check({14'h0, test_start}, {14'h0, 2'b01 << g});
        rd(ta, {1'b1, prev_word[g][14:0]});
        wr(sa, sd);
        #1 check({14'h0, test_start}, 16'h0000);
        @(posedge mclk);
        test_done[g] <= 1'b1;
        test_result[2*g +: 2] <= code;
        test_short[g] <= sh;
        test_count[9*g +: 9] <= cnt;
        @(posedge mclk);
        test_done <= 2'b00;
        test_result[2*g +: 2] <= ~code;
        test_short[g] <= ~sh;
        test_count[9*g +: 9] <= ~cnt;
        prev_word[g] = exp;
        rd(ta, exp);
    endtask : run_test

    ////////////////////////////////////////////////////////////////////////////////
    // Watchdog: the sequence needs well under 1000 cycles.
    initial begin
        #100000;
        err_count++;
        final_report();
    end

    // Main sequence.
    initial begin
        repeat (8) @(posedge mclk);
        rst <= 1'b0;
        rd(16'h2F02, 16'h0014);
        rd(16'h2F06, 16'h0014);
        rd(16'h2F04, 16'h0000);
        rd(16'h3100, 16'h0400);
        wr(16'h2F02, 16'hFFFF);
        rd(16'h2F02, 16'h001E);
        check({13'h0, force_link[0], power_save_off[0], near_loopback[0]}, 16'h0007);
        rd(16'h3100, 16'h0E00);
        wr(16'h3100, 16'h0000);
        rd(16'h2F02, 16'h0010);
        check({13'h0, force_link[0], power_save_off[0], near_loopback[0]}, 16'h0000);
        wr(16'h2F06, 16'h0008);
        @(posedge mclk);
        polarity_reversed <= 2'b10;
        crossover_state <= 2'b01;
        rd(16'h2F06, 16'h0028);
        check({13'h0, force_link[1], power_save_off[1], near_loopback[1]}, 16'h0004);
        rd(16'h3304, 16'h2000);
        rd(16'h2F08, 16'h0028);
        check({15'h0, irq}, 16'h0000);
        wr(16'h2F0A, 16'h003F);
        rd(16'h2F0A, 16'h003F);
        check({15'h0, irq}, 16'h0001);
        wr(16'h2F08, 16'h0028);
        rd(16'h2F08, 16'h0000);
        check({15'h0, irq}, 16'h0000);
        // Every result code, started alternately through both views.
        for (int i = 0; i < 4; i++) begin
            if (i % 2 == 0) begin
                run_test(1, 16'h2F04, 16'h8000, 2'(i), 1'(i), 9'(16'h0055 * i + 1), 16'h2F04);
            end else begin
                run_test(1, 16'h3300, 16'h1800, 2'(i), 1'(i), 9'(16'h0055 * i + 1), 16'h2F04);
            end
        end
        rd(16'h3300, 16'hE900);
        run_test(0, 16'h2F00, 16'h8000, 2'b01, 1'b1, 9'h1A5, 16'h2F00);
        @(posedge mclk);
        test_done[0] <= 1'b1;
        test_result[1:0] <= 2'b11;
        @(posedge mclk);
        test_done <= 2'b00;
        rd(16'h2F00, 16'h31A5);
        rd(16'h2F08, 16'h0003);
        check({15'h0, irq}, 16'h0001);
        wr(16'h2F08, 16'h0003);
        rd(16'h2F08, 16'h0000);
        check({15'h0, irq}, 16'h0000);
        wr(16'h2F0C, 16'hFFFF);
        rd(16'h2F0C, 16'h0000);
        // A write with the clock enable low must leave every field alone.
        ce <= 1'b0;
        wr(16'h2F02, 16'h000E);
        ce <= 1'b1;
        rd(16'h2F02, 16'h0010);
        rd(16'h2F06, 16'h0028);
        final_report();
    end
endmodule : psc_regs_tb
